// file: rtl/keypad_tone_params.svh
// constants for the keypad dual-tone generator control logic
// assumes a single 50 MHz clock standing in for the crystal oscillator
`ifndef KEYPAD_TONE_PARAMS_SVH
`define KEYPAD_TONE_PARAMS_SVH
`define CLK_HZ 50000000
`define DEB_TIME_US 1000
`define SETTLE_TIME_US 3000
`define DEB_CYC (`DEB_TIME_US * (`CLK_HZ / 1000000))
`define SETTLE_CYC (`SETTLE_TIME_US * (`CLK_HZ / 1000000))
`define TEST_MULT 16
`define F_ROW_A 697
`define F_ROW_B 770
`define F_ROW_C 852
`define F_ROW_D 941
`define F_COL_A 1209
`define F_COL_B 1336
`define F_COL_C 1477
`define F_COL_D 1633
`define KEY1_ROW 4'h1
`define KEY1_COL 4'h1
`define KEYA_ROW 4'h1
`define KEYA_COL 4'h8
`define KEYD_ROW 4'h8
`define KEYD_COL 4'h8
`endif

// file: rtl/keypad_tone_pkg.sv
// types shared by the keypad tone generator and its tone divider
// assumes the constants header is compiled alongside
`default_nettype none
package keypad_tone_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SCAN = 2'h1,
    ST_SETTLE = 2'h3,
    ST_TONE = 2'h2
  } tone_state_e;
  typedef struct packed {
    logic [3:0] row;
    logic [3:0] col;
  } key_bus_s;
  typedef struct packed {
    tone_state_e state;
    logic [17:0] cnt;
    key_bus_s s1;
    key_bus_s s2;
    key_bus_s sel;
    logic test_mode;
    logic wait_rel;
    logic mute;
    logic tone_en;
  } ctrl_state_s;
  typedef struct packed {
    logic [11:0] cnt;
    logic x16;
    logic [3:0] div;
  } div_state_s;
endpackage
`default_nettype wire

// file: rtl/tone_divider.sv
// programmable divider giving a tone square wave and its x16 test rate
// assumes a synchronised reset and a half-period count that is stable while enabled
`default_nettype none
module tone_divider (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic en_i,
  input wire logic [11:0] half_cnt_i,
  // outputs
  output logic x16_o,
  output logic tone_o
);
  import keypad_tone_pkg::*;
  div_state_s st_reg;
  div_state_s st_next;

  // x16 toggles every half_cnt+1 cycles, tone is x16 divided by sixteen
  always_comb
  begin
    st_next = st_reg;
    if (!en_i)
    begin
      st_next = '0; // stopped divider models the gated oscillator
    end
    else if (st_reg.cnt >= half_cnt_i)
    begin
      st_next.cnt = 12'h0;
      st_next.x16 = ~st_reg.x16;
      if (!st_reg.x16)
      begin
        st_next.div = st_reg.div + 4'h1;
      end
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 12'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign x16_o = st_reg.x16;
  assign tone_o = st_reg.div[3];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // a toggle sampled now was launched by a full count on the previous edge
  a_x16_period: assert property ($changed(x16_o) && en_i |->
    $past(st_reg.cnt) >= $past(half_cnt_i))
    else $error("x16 toggled before half period");
  a_tone_edge: assert property ($changed(tone_o) && en_i |-> $rose(x16_o))
    else $error("tone changed without x16 rise");
endmodule
`default_nettype wire

// file: rtl/keypad_tone_gen.sv
// keypad scan, mute, test mode and tone gating for a dual-tone generator
// assumes keypad pins are asynchronous and high when a key connects them
`include "keypad_tone_params.svh"
`default_nettype none
module keypad_tone_gen #(
  parameter int DEB_CYC = `DEB_CYC,
  parameter int SETTLE_CYC = `SETTLE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // keypad rows
  input wire logic row_in_a_i,
  input wire logic row_in_b_i,
  input wire logic row_in_c_i,
  input wire logic row_in_d_i,
  // keypad columns
  input wire logic col_in_a_i,
  input wire logic col_in_b_i,
  input wire logic col_in_c_i,
  input wire logic col_in_d_i,
  // status
  output logic osc_run_o,
  output logic mute_o,
  output logic test_mode_o,
  // tone outputs
  output logic tone_en_o,
  output logic low_tone_o,
  output logic high_tone_o,
  // open-drain test-rate output
  output logic test_freq_o,
  output logic test_freq_oe_o
);
  import keypad_tone_pkg::*;

  localparam logic [17:0] DEB_LAST = 18'(DEB_CYC - 1);
  localparam logic [17:0] SETTLE_LAST = 18'(SETTLE_CYC - 1);

  ctrl_state_s st_reg;
  ctrl_state_s st_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  key_bus_s keys;
  logic any_key;
  logic test_pat;
  logic key_ok;
  logic low_en;
  logic high_en;
  logic single;
  logic [11:0] low_half;
  logic [11:0] high_half;
  logic low_x16;
  logic high_x16;
  logic low_tone;
  logic high_tone;

  function automatic logic onehot4(input logic [3:0] v);
    onehot4 = (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
  endfunction

  function automatic logic [11:0] half_cnt_f(input logic [3:0] sel, input logic is_col);
    int f;
    f = 1;
    unique case (sel)
      4'h1: f = is_col ? `F_COL_A : `F_ROW_A;
      4'h2: f = is_col ? `F_COL_B : `F_ROW_B;
      4'h4: f = is_col ? `F_COL_C : `F_ROW_C;
      4'h8: f = is_col ? `F_COL_D : `F_ROW_D;
      default: f = 1; // no selection, divider is stopped anyway
    endcase
    // rounded cycles per half period of the x16 rate, minus one
    half_cnt_f = 12'((`CLK_HZ + `TEST_MULT * f) / (2 * `TEST_MULT * f) - 1);
  endfunction

  // reset release through two flops, assert stays asynchronous
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // key decode, read only from the second synchroniser stage
  always_comb
  begin
    keys = st_reg.s2;
    any_key = |{keys.row, keys.col};
    test_pat = (keys.row == (`KEY1_ROW | `KEYA_ROW | `KEYD_ROW)) &&
      (keys.col == (`KEY1_COL | `KEYA_COL | `KEYD_COL));
    if (st_reg.test_mode)
      key_ok = any_key && (onehot4(keys.row) || keys.row == 4'h0) &&
        (onehot4(keys.col) || keys.col == 4'h0);
    else
      key_ok = onehot4(keys.row) && onehot4(keys.col);
  end

  // scan, debounce, oscillator settle and tone control
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = key_bus_s'({row_in_d_i, row_in_c_i, row_in_b_i, row_in_a_i,
      col_in_d_i, col_in_c_i, col_in_b_i, col_in_a_i});
    st_next.s2 = st_reg.s1;
    unique case (st_reg.state)
      ST_IDLE:
      begin
        st_next.mute = 1'b0;
        st_next.tone_en = 1'b0;
        if (any_key)
        begin
          st_next.state = ST_SCAN;
          st_next.cnt = 18'h0;
          st_next.sel = keys;
          st_next.wait_rel = 1'b0;
        end
      end
      ST_SCAN:
      begin
        if (!any_key)
        begin
          st_next.state = ST_IDLE;
        end
        else if (st_reg.wait_rel)
        begin
          st_next.cnt = 18'h0; // hold until all keys released
        end
        else if (keys != st_reg.sel)
        begin
          st_next.sel = keys; // bounce restarts the debounce time
          st_next.cnt = 18'h0;
        end
        else if (st_reg.cnt >= DEB_LAST)
        begin
          if (test_pat)
          begin
            st_next.test_mode = ~st_reg.test_mode;
            st_next.wait_rel = 1'b1;
          end
          else if (key_ok)
          begin
            st_next.state = ST_SETTLE;
            st_next.mute = 1'b1;
            st_next.cnt = 18'h0;
          end
        end
        else
        begin
          st_next.cnt = st_reg.cnt + 18'h1;
        end
      end
      ST_SETTLE:
      begin
        if (keys != st_reg.sel)
        begin
          st_next.state = ST_IDLE;
          st_next.mute = 1'b0;
        end
        else if (st_reg.cnt >= SETTLE_LAST)
        begin
          st_next.state = ST_TONE;
          st_next.tone_en = 1'b1;
        end
        else
        begin
          st_next.cnt = st_reg.cnt + 18'h1;
        end
      end
      ST_TONE:
      begin
        // any change ends the burst; a new press is scanned afresh
        if (keys != st_reg.sel)
        begin
          st_next.state = ST_IDLE;
          st_next.mute = 1'b0;
          st_next.tone_en = 1'b0;
        end
      end
    endcase
  end

  // test mode is cleared by reset or toggled off by the test pattern again
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // divider selection from the latched key
  always_comb
  begin
    low_half = half_cnt_f(st_reg.sel.row, 1'b0);
    high_half = half_cnt_f(st_reg.sel.col, 1'b1);
    low_en = st_reg.tone_en && (st_reg.sel.row != 4'h0);
    high_en = st_reg.tone_en && (st_reg.sel.col != 4'h0);
    single = low_en ^ high_en;
  end

  tone_divider u_low_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .en_i(low_en),
    .half_cnt_i(low_half),
    .x16_o(low_x16),
    .tone_o(low_tone)
  );

  tone_divider u_high_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .en_i(high_en),
    .half_cnt_i(high_half),
    .x16_o(high_x16),
    .tone_o(high_tone)
  );

  // outputs; the open-drain pin only ever pulls low
  assign osc_run_o = (st_reg.state != ST_IDLE);
  assign mute_o = st_reg.mute;
  assign test_mode_o = st_reg.test_mode;
  assign tone_en_o = st_reg.tone_en;
  assign low_tone_o = low_tone;
  assign high_tone_o = high_tone;
  assign test_freq_o = 1'b0;
  assign test_freq_oe_o = single && !(low_en ? low_x16 : high_x16);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_standby_idle: assert property (st_reg.state == ST_IDLE && !any_key |=>
    !osc_run_o && !tone_en_o)
    else $error("oscillator running without key");
  a_scan_start: assert property (st_reg.state == ST_IDLE && any_key |=> osc_run_o)
    else $error("key did not start scan");
  a_no_multi_tone: assert property (tone_en_o && !test_mode_o |->
    onehot4(st_reg.sel.row) && onehot4(st_reg.sel.col))
    else $error("tone with several rows or columns");
  a_row_a_freq: assert property (st_reg.sel.row == 4'h1 |-> low_half == 12'h8c1)
    else $error("wrong first row divider");
  a_col_a_freq: assert property (st_reg.sel.col == 4'h1 |-> high_half == 12'h50b)
    else $error("wrong first column divider");
  a_test_single: assert property (test_freq_oe_o |-> tone_en_o && single)
    else $error("test output driven without single tone");
  a_mute_hold: assert property (tone_en_o |-> mute_o)
    else $error("tones without mute");
  a_early_release: assert property (st_reg.state == ST_SETTLE && keys != st_reg.sel |=>
    !mute_o ##1 !tone_en_o)
    else $error("mute kept after early release");
  a_tone_gate: assert property ($rose(tone_en_o) |-> $past(st_reg.state) == ST_SETTLE &&
    $past(st_reg.cnt) >= SETTLE_LAST)
    else $error("tones released before settle");
  a_test_toggle: assert property (st_reg.state == ST_SCAN && !st_reg.wait_rel &&
    keys == st_reg.sel && st_reg.cnt >= DEB_LAST && test_pat && any_key |=>
    test_mode_o != $past(test_mode_o))
    else $error("test pattern did not toggle test mode");

  c_tone_burst: cover property ($rose(tone_en_o));
  c_test_enter: cover property ($rose(test_mode_o));
  c_early_abort: cover property ($fell(mute_o) && !$past(tone_en_o));
  c_single_tone: cover property (tone_en_o && single);
endmodule
`default_nettype wire

// file: sim/keypad_model.sv
// behavioural four by four single-contact keypad with logic-level test drive
// assumes device lines have pull-downs, so an open line reads low
`default_nettype none
module keypad_model (
  // key contacts, index is row times four plus column
  input wire logic [15:0] keys_i,
  // logic-level sources, the only way to raise a row or column line on its own
  input wire keypad_tone_pkg::key_bus_s drive_i,
  // lines to the device
  output var keypad_tone_pkg::key_bus_s pins_o
);
  import keypad_tone_pkg::*;
  // a closed contact joins its row and column, both read high
  always_comb
  begin
    pins_o = drive_i;
    for (int i = 0; i < 16; i++)
    begin
      if (keys_i[i])
      begin
        pins_o.row[i / 4] = 1'b1;
        pins_o.col[i % 4] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the keypad tone generator control logic
// assumes the constants header and package are compiled first
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import keypad_tone_pkg::*;
  localparam int DEB = 4;
  localparam int SET = 6;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] keys = '0;
  key_bus_s drv = '0;
  key_bus_s pins;
  logic osc_run, mute, test_mode, tone_en, low_tone, high_tone, test_freq, test_freq_oe;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;

  keypad_model pad (.keys_i(keys), .drive_i(drv), .pins_o(pins));

  keypad_tone_gen #(.DEB_CYC(DEB), .SETTLE_CYC(SET)) DUT (
    .clk_i(clk), .arst_n_i(arst_n),
    .row_in_a_i(pins.row[0]), .row_in_b_i(pins.row[1]),
    .row_in_c_i(pins.row[2]), .row_in_d_i(pins.row[3]),
    .col_in_a_i(pins.col[0]), .col_in_b_i(pins.col[1]),
    .col_in_c_i(pins.col[2]), .col_in_d_i(pins.col[3]),
    .osc_run_o(osc_run), .mute_o(mute), .test_mode_o(test_mode),
    .tone_en_o(tone_en), .low_tone_o(low_tone), .high_tone_o(high_tone),
    .test_freq_o(test_freq), .test_freq_oe_o(test_freq_oe)
  );

  // 50 MHz clock
  initial
  begin
    forever #10 clk = ~clk;
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, well above the longest tone measurements
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic chk_n(input int got, input int exp, input string what);
    checks_done++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s got %0d want %0d", $time, what, got, exp);
    end
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return osc_run;
      1: return mute;
      2: return tone_en;
      3: return test_mode;
      default: return test_freq_oe;
    endcase
  endfunction

  // outputs are read at falling edges, where they have settled
  task automatic wait_lvl(input int s, input logic lvl, input int lim, input string what);
    int n;
    n = 0;
    while (sig(s) !== lvl && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk(sig(s), lvl, what);
  endtask

  task automatic t_key(input int k);
    keys = 16'h0001 << k;
    repeat (2) @(negedge clk);
    chk(osc_run, 1'b0, "osc early");
    @(negedge clk);
    chk(osc_run, 1'b1, "osc start");
    wait_lvl(1, 1'b1, DEB + 4, "mute set");
    chk(tone_en, 1'b0, "tone before settle");
    wait_lvl(2, 1'b1, SET + 2, "tone on");
    repeat (40)
    begin
      @(negedge clk);
      chk(mute, 1'b1, "mute held");
      chk(test_freq_oe, 1'b0, "test out two tones");
    end
    keys = '0;
    wait_lvl(2, 1'b0, 5, "tone off");
    chk(mute, 1'b0, "mute off");
    wait_lvl(0, 1'b0, 10, "standby");
  endtask

  task automatic t_refuse();
    logic [15:0] km [3] = '{16'h0011, 16'h0003, 16'h0000};
    key_bus_s dm [3] = '{8'h00, 8'h00, 8'h20};
    for (int i = 0; i < 3; i++)
    begin
      keys = km[i];
      drv = dm[i];
      repeat (4) @(negedge clk);
      chk(osc_run, 1'b1, "scan runs");
      repeat (DEB + SET + 20)
      begin
        @(negedge clk);
        chk(tone_en, 1'b0, "illegal tone");
        chk(mute, 1'b0, "illegal mute");
      end
      keys = '0;
      drv = '0;
      wait_lvl(0, 1'b0, 10, "standby");
    end
  endtask

  // release lands inside the settle time, so tones must never start
  task automatic t_early();
    keys = 16'h0020;
    wait_lvl(1, 1'b1, DEB + 8, "mute set");
    keys = '0;
    wait_lvl(1, 1'b0, 5, "mute drop");
    repeat (20)
    begin
      @(negedge clk);
      chk(tone_en, 1'b0, "aborted tone");
    end
  endtask

  task automatic t_test();
    int f [8] = '{697, 770, 852, 941, 1209, 1336, 1477, 1633};
    int half;
    int n;
    drv = '{row: 4'h9, col: 4'h9};
    wait_lvl(3, 1'b1, DEB + 10, "test entry");
    drv = '0;
    repeat (10) @(negedge clk);
    for (int i = 0; i < 8; i++)
    begin
      half = (50000000 + 16 * f[i]) / (32 * f[i]);
      if (i < 4)
        drv = key_bus_s'{row: 4'h1 << i, col: 4'h0};
      else
        drv = key_bus_s'{row: 4'h0, col: 4'h1 << (i - 4)};
      wait_lvl(2, 1'b1, DEB + SET + 10, "single tone");
      wait_lvl(4, 1'b1, 2 * half + 10, "test out");
      n = 0;
      while (test_freq_oe === 1'b1 && n < 5000)
      begin
        @(negedge clk);
        n++;
      end
      chk_n(n, half, "x16 half period");
      chk(test_freq, 1'b0, "open drain level");
      // tone rises on the eighth x16 rise, seven x16 periods after the first
      if (i == 3 || i == 7)
      begin
        n = 0;
        while (((i < 4) ? low_tone : high_tone) !== 1'b1 && n < 30000)
        begin
          @(negedge clk);
          n++;
        end
        chk_n(n, 14 * half, "tone rise after x16");
      end
      drv = '0;
      wait_lvl(2, 1'b0, 10, "tone off");
      repeat (10) @(negedge clk);
    end
    drv = '{row: 4'h1, col: 4'h2};
    wait_lvl(2, 1'b1, DEB + SET + 10, "both tones");
    repeat (100)
    begin
      @(negedge clk);
      chk(test_freq_oe, 1'b0, "test out two tones");
    end
    drv = '{row: 4'h9, col: 4'h9};
    wait_lvl(3, 1'b0, DEB + 20, "test exit");
    drv = '0;
    repeat (10) @(negedge clk);
  endtask

  // a power cycle mid-run must drop test mode and leave the scan idle
  task automatic t_reset();
    drv = '{row: 4'h9, col: 4'h9};
    wait_lvl(3, 1'b1, DEB + 10, "test entry again");
    drv = '0;
    repeat (6) @(negedge clk);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(test_mode, 1'b0, "reset test mode");
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(osc_run, 1'b0, "reset osc");
    chk(mute, 1'b0, "reset mute");
    repeat (4) @(negedge clk);
    chk(test_mode, 1'b0, "test mode after reset");
  endtask

  // main sequence
  initial
  begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (20) @(negedge clk);
    chk(osc_run, 1'b0, "idle osc");
    chk(low_tone, 1'b0, "idle tone");
    chk(high_tone, 1'b0, "idle high tone");
    for (int k = 0; k < 16; k++)
      t_key(k);
    t_refuse();
    t_early();
    t_test();
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
